// file: include/udrt_defines.svh
// Register map, field positions, reset values and timing for the reload timer
`ifndef UDRT_DEFINES_SVH
`define UDRT_DEFINES_SVH
// ==========================================
// Register offsets (byte addresses)
`define UDRT_CTRL_OFS 8'h00
`define UDRT_MODE_OFS 8'h04
`define UDRT_CNTL_OFS 8'h08
`define UDRT_CNTH_OFS 8'h0C
`define UDRT_RLDL_OFS 8'h10
`define UDRT_RLDH_OFS 8'h14
`define UDRT_ISTAT_OFS 8'h18
`define UDRT_IMASK_OFS 8'h1C
// ==========================================
// Control register fields
`define UDRT_CTRL_OVF 7
`define UDRT_CTRL_EXTF 6
`define UDRT_CTRL_RCLK 5
`define UDRT_CTRL_TRANSMIT_CLOCK_SELECT 4
`define UDRT_CTRL_EXEN 3
`define UDRT_CTRL_RUN 2
`define UDRT_CTRL_CSEL 1
`define UDRT_CTRL_CPRL 0
// Mode register field
`define UDRT_MODE_UDEN 0
// Interrupt status and mask fields
`define UDRT_IRQ_OVF 0
`define UDRT_IRQ_EXTF 1
// ==========================================
// Reset values
`define UDRT_CTRL_RST 8'h00
`define UDRT_MODE_RST 1'h0
`define UDRT_CNT_RST 16'h0000
`define UDRT_RLD_RST 16'h0000
`define UDRT_IRQ_RST 2'h0
// ==========================================
// Timing
`define UDRT_PRESCALE 12
`define UDRT_CNT_MAX 16'hFFFF
`endif

// file: include/udrt_pkg.sv
// Types shared by the reload timer
package udrt_pkg;
   // ==========================================
   // Operating modes
   typedef enum logic [1:0] {
      UDRT_RELOAD = 2'b00,
      UDRT_CAPTURE = 2'b01,
      UDRT_BAUD = 2'b10
   } udrt_mode_type;
endpackage : udrt_pkg

// file: logic/udrt_timer.sv
// Sixteen-bit up/down auto-reload timer with a Wishbone register port
`timescale 1ns/1ps
`include "udrt_defines.svh"

// Notes on behaviour
// - Count is low byte plus high byte; high advances on low byte carry.
// - Counter select clear: clock divided by 12; set: external count pin.
// - Low byte advances on the selected source only while run is set.
// - Three modes from receive, transmit clock and capture/reload selects.
// - Up/down enable clear: plain up-counting reload, direction pin used only as the external reload trigger.
// - Up/down enable set in reload mode: direction pin picks direction.
// - Counting up past FFFFh outside baud mode sets overflow flag and requests interrupt.
// - Up overflow loads reload high and low bytes into the count; capture mode loads zero.
// - Counting down, underflow when count equals the reload value.
// - Down underflow sets overflow flag and loads FFFFh, ignoring reload.
// - Up/down mode toggles external flag on each wrap, no interrupt.
// - Overflow flag set only when both clock selects are zero; software clears.
// - Counter operation advances on each falling edge of the count pin.
module udrt_timer #(
   parameter int PRESCALE = `UDRT_PRESCALE
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pins
   input wire logic count_input_pin_i,
   input wire logic direction_pin_i,
   // Interrupt
   output logic irq_o
);

   // ==========================================
   // State
   logic [7:0] timer_control_reg_r, timer_control_reg_nxt;
   logic updown_enable_bit_r, updown_enable_bit_nxt;
   logic [7:0] count_low_byte_r, count_low_byte_nxt;
   logic [7:0] count_high_byte_r, count_high_byte_nxt;
   logic [7:0] reload_low_byte_r, reload_low_byte_nxt;
   logic [7:0] reload_high_byte_r, reload_high_byte_nxt;
   logic [1:0] irq_stat_r, irq_stat_nxt;
   logic [1:0] irq_mask_r, irq_mask_nxt;
   logic [3:0] presc_r, presc_nxt;
   logic cpin_s1_r, cpin_s2_r, cpin_prev_r;
   logic dpin_s1_r, dpin_s2_r, dpin_prev_r;
   logic cpin_s1_nxt, cpin_s2_nxt, cpin_prev_nxt;
   logic dpin_s1_nxt, dpin_s2_nxt, dpin_prev_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic ack_r, ack_nxt;
   logic irq_r, irq_nxt;

   // ==========================================
   // Decode
   logic run, csel, uden, exen, ovf_allowed;
   logic tick, cpin_fall, dpin_fall, count_up;
   logic [15:0] count, reload;
   logic wr, rd_hit;
   udrt_pkg::udrt_mode_type mode;

   assign run = timer_control_reg_r[`UDRT_CTRL_RUN];
   assign csel = timer_control_reg_r[`UDRT_CTRL_CSEL];
   assign exen = timer_control_reg_r[`UDRT_CTRL_EXEN];
   assign uden = updown_enable_bit_r;
   assign count = {count_high_byte_r, count_low_byte_r};
   assign reload = {reload_high_byte_r, reload_low_byte_r};
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r & wb_sel_i[0];
   // Only the synchronised copies are compared
   assign cpin_fall = cpin_prev_r & ~cpin_s2_r;
   assign dpin_fall = dpin_prev_r & ~dpin_s2_r;
   // Overflow flag source is cut while either serial clock select is set
   assign ovf_allowed = ~timer_control_reg_r[`UDRT_CTRL_RCLK]
      & ~timer_control_reg_r[`UDRT_CTRL_TRANSMIT_CLOCK_SELECT];

   always_comb begin
      // Baud selects take priority over capture/reload
      if (timer_control_reg_r[`UDRT_CTRL_RCLK] | timer_control_reg_r[`UDRT_CTRL_TRANSMIT_CLOCK_SELECT]) begin
         mode = udrt_pkg::UDRT_BAUD;
      end else if (timer_control_reg_r[`UDRT_CTRL_CPRL]) begin
         mode = udrt_pkg::UDRT_CAPTURE;
      end else begin
         mode = udrt_pkg::UDRT_RELOAD;
      end
   end

   // ==========================================
   // Pin synchronisers
   // Two stages against metastability, a third for the edge compare
   always_comb begin
      cpin_s1_nxt = count_input_pin_i;
      cpin_s2_nxt = cpin_s1_r;
      cpin_prev_nxt = cpin_s2_r;
      dpin_s1_nxt = direction_pin_i;
      dpin_s2_nxt = dpin_s1_r;
      dpin_prev_nxt = dpin_s2_r;
   end

   // Held high in reset so an idle high pin gives no false edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpin_s1_r <= 1'b1;
         cpin_s2_r <= 1'b1;
         cpin_prev_r <= 1'b1;
         dpin_s1_r <= 1'b1;
         dpin_s2_r <= 1'b1;
         dpin_prev_r <= 1'b1;
      end else begin
         cpin_s1_r <= cpin_s1_nxt;
         cpin_s2_r <= cpin_s2_nxt;
         cpin_prev_r <= cpin_prev_nxt;
         dpin_s1_r <= dpin_s1_nxt;
         dpin_s2_r <= dpin_s2_nxt;
         dpin_prev_r <= dpin_prev_nxt;
      end
   end

   // ==========================================
   // Count source
   always_comb begin
      presc_nxt = presc_r;
      tick = 1'b0;
      if (!run) begin
         presc_nxt = 4'h0;
      end else if (csel) begin
         tick = cpin_fall;
      end else if (presc_r == 4'(PRESCALE - 1)) begin
         presc_nxt = 4'h0;
         tick = 1'b1;
      end else begin
         presc_nxt = presc_r + 4'h1;
      end
   end

   // Cleared while stopped so a restart waits a full period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_r <= 4'h0;
      end else begin
         presc_r <= presc_nxt;
      end
   end

   // Direction only matters in reload mode with up/down enabled
   assign count_up = ~(uden & (mode == udrt_pkg::UDRT_RELOAD)) | dpin_s2_r;

   // ==========================================
   // Counter, flags and registers
   always_comb begin
      logic [8:0] low_sum;
      logic wrap_up, wrap_down, set_ovf, tog_ext, set_ext;
      low_sum = 9'h000;
      wrap_up = 1'b0;
      wrap_down = 1'b0;
      set_ovf = 1'b0;
      tog_ext = 1'b0;
      set_ext = 1'b0;
      timer_control_reg_nxt = timer_control_reg_r;
      updown_enable_bit_nxt = updown_enable_bit_r;
      count_low_byte_nxt = count_low_byte_r;
      count_high_byte_nxt = count_high_byte_r;
      reload_low_byte_nxt = reload_low_byte_r;
      reload_high_byte_nxt = reload_high_byte_r;
      irq_stat_nxt = irq_stat_r;
      irq_mask_nxt = irq_mask_r;

      if (tick && count_up) begin
         if (count == `UDRT_CNT_MAX) begin
            wrap_up = 1'b1;
            if (mode == udrt_pkg::UDRT_CAPTURE) begin
               count_low_byte_nxt = 8'h00;
               count_high_byte_nxt = 8'h00;
            end else begin
               count_low_byte_nxt = reload_low_byte_r;
               count_high_byte_nxt = reload_high_byte_r;
            end
         end else begin
            low_sum = {1'b0, count_low_byte_r} + 9'h001;
            count_low_byte_nxt = low_sum[7:0];
            count_high_byte_nxt = count_high_byte_r + {7'h00, low_sum[8]};
         end
      end else if (tick) begin
         if (count == reload) begin
            wrap_down = 1'b1;
            count_low_byte_nxt = 8'(`UDRT_CNT_MAX);
            count_high_byte_nxt = 8'hFF;
         end else begin
            count_low_byte_nxt = count_low_byte_r - 8'h01;
            count_high_byte_nxt = count_high_byte_r
               - {7'h00, (count_low_byte_r == 8'h00)};
         end
      end

      // Wrap flags
      set_ovf = (wrap_up | wrap_down) & ovf_allowed;
      if (uden && mode == udrt_pkg::UDRT_RELOAD) begin
         tog_ext = wrap_up | wrap_down;
      end else if (exen && dpin_fall && run && mode != udrt_pkg::UDRT_BAUD) begin
         set_ext = 1'b1;
         if (mode == udrt_pkg::UDRT_RELOAD) begin
            count_low_byte_nxt = reload_low_byte_r;
            count_high_byte_nxt = reload_high_byte_r;
         end
      end

      // Software access; a write to the count beats a tick
      if (wr) begin
         unique case (wb_adr_i & 8'hFC)
            `UDRT_CTRL_OFS: timer_control_reg_nxt = wb_dat_i[7:0];
            `UDRT_MODE_OFS: updown_enable_bit_nxt = wb_dat_i[`UDRT_MODE_UDEN];
            `UDRT_CNTL_OFS: count_low_byte_nxt = wb_dat_i[7:0];
            `UDRT_CNTH_OFS: count_high_byte_nxt = wb_dat_i[7:0];
            `UDRT_RLDL_OFS: reload_low_byte_nxt = wb_dat_i[7:0];
            `UDRT_RLDH_OFS: reload_high_byte_nxt = wb_dat_i[7:0];
            `UDRT_ISTAT_OFS: irq_stat_nxt = irq_stat_r & ~wb_dat_i[1:0];
            `UDRT_IMASK_OFS: irq_mask_nxt = wb_dat_i[1:0];
            default: ;
         endcase
      end

      // Hardware set wins over a clearing write
      if (set_ovf) begin
         timer_control_reg_nxt[`UDRT_CTRL_OVF] = 1'b1;
         irq_stat_nxt[`UDRT_IRQ_OVF] = 1'b1;
      end
      if (tog_ext) begin
         timer_control_reg_nxt[`UDRT_CTRL_EXTF] = ~timer_control_reg_r[`UDRT_CTRL_EXTF];
      end
      if (set_ext) begin
         timer_control_reg_nxt[`UDRT_CTRL_EXTF] = 1'b1;
         irq_stat_nxt[`UDRT_IRQ_EXTF] = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_control_reg_r <= `UDRT_CTRL_RST;
         updown_enable_bit_r <= `UDRT_MODE_RST;
         // Count bytes reset as one sixteen-bit word
         {count_high_byte_r, count_low_byte_r} <= `UDRT_CNT_RST;
         {reload_high_byte_r, reload_low_byte_r} <= `UDRT_RLD_RST;
         irq_stat_r <= `UDRT_IRQ_RST;
         irq_mask_r <= `UDRT_IRQ_RST;
      end else begin
         timer_control_reg_r <= timer_control_reg_nxt;
         updown_enable_bit_r <= updown_enable_bit_nxt;
         count_low_byte_r <= count_low_byte_nxt;
         count_high_byte_r <= count_high_byte_nxt;
         reload_low_byte_r <= reload_low_byte_nxt;
         reload_high_byte_r <= reload_high_byte_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
      end
   end

   // ==========================================
   // Bus answer
   always_comb begin
      ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
      rd_hit = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;
      dat_nxt = 32'h0000_0000;
      if (rd_hit) begin
         unique case (wb_adr_i & 8'hFC)
            `UDRT_CTRL_OFS: dat_nxt = {24'h000000, timer_control_reg_r};
            `UDRT_MODE_OFS: dat_nxt = {31'h0000_0000, updown_enable_bit_r};
            `UDRT_CNTL_OFS: dat_nxt = {24'h000000, count_low_byte_r};
            `UDRT_CNTH_OFS: dat_nxt = {24'h000000, count_high_byte_r};
            `UDRT_RLDL_OFS: dat_nxt = {24'h000000, reload_low_byte_r};
            `UDRT_RLDH_OFS: dat_nxt = {24'h000000, reload_high_byte_r};
            `UDRT_ISTAT_OFS: dat_nxt = {30'h0000_0000, irq_stat_r};
            `UDRT_IMASK_OFS: dat_nxt = {30'h0000_0000, irq_mask_r};
            default: dat_nxt = 32'h0000_0000;
         endcase
      end
      // Level from registered state, one cycle behind the status
      irq_nxt = |(irq_stat_r & irq_mask_r);
   end

   // Data cleared when idle so the bus sees zero between answers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= 32'h0000_0000;
         ack_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         dat_r <= dat_nxt;
         ack_r <= ack_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign irq_o = irq_r;

endmodule : udrt_timer

// file: verification/tb.sv
// Self-checking bench for the reload timer
`timescale 1ns/1ps
`include "udrt_defines.svh"
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic go = 1'b0;
   logic dir = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, got;
   logic ack, irq, cpin, dpin;
   int errors = 0;
   int cmp_count = 0;
   udrt_timer u_udrt_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .count_input_pin_i(cpin), .direction_pin_i(dpin), .irq_o(irq));
   udrt_pin_model u_udrt_pin_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .dir_i(dir),
      .count_pin_o(cpin), .dir_pin_o(dpin));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   // ==========================================
   // Shared tasks
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // No wait limit here: only the watchdog ends a hung request
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      got = rdat;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic chk(input logic [31:0] e);
      cmp_count++;
      if (got !== e) begin
         errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, e);
      end
   endtask : chk
   task automatic chk_irq(input logic e);
      cmp_count++;
      if (irq !== e) begin
         errors++;
         $display("CHECK FAILED %0t irq %b want %b", $time, irq, e);
      end
   endtask : chk_irq
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(e);
   endtask : rd
   task automatic pulse();
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (10) @(posedge clk_i);
   endtask : pulse
   // ==========================================
   // Scenarios
   task automatic test_reset();
      rd(`UDRT_CTRL_OFS, 32'h0);
      rd(`UDRT_CNTH_OFS, 32'h0);
      rd(8'h20, 32'h0);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_carry();
      wb(1'b1, `UDRT_CNTL_OFS, 32'hFF);
      wb(1'b1, `UDRT_CTRL_OFS, 32'h04);
      repeat (18) @(posedge clk_i);
      wb(1'b1, `UDRT_CTRL_OFS, 32'h00);
      rd(`UDRT_CNTL_OFS, 32'h00);
      rd(`UDRT_CNTH_OFS, 32'h01);
      repeat (30) @(posedge clk_i);
      rd(`UDRT_CNTL_OFS, 32'h00);
      $display("test_carry done");
   endtask : test_carry
   task automatic test_overflow();
      wb(1'b1, `UDRT_RLDL_OFS, 32'h34);
      wb(1'b1, `UDRT_RLDH_OFS, 32'h12);
      wb(1'b1, `UDRT_CNTL_OFS, 32'hFF);
      wb(1'b1, `UDRT_CNTH_OFS, 32'hFF);
      wb(1'b1, `UDRT_IMASK_OFS, 32'h01);
      wb(1'b1, `UDRT_CTRL_OFS, 32'h04);
      repeat (14) @(posedge clk_i);
      rd(`UDRT_CNTL_OFS, 32'h34);
      rd(`UDRT_CTRL_OFS, 32'h84);
      chk_irq(1'b1);
      wb(1'b1, `UDRT_CTRL_OFS, 32'h00);
      wb(1'b1, `UDRT_ISTAT_OFS, 32'h01);
      chk_irq(1'b0);
      $display("test_overflow done");
   endtask : test_overflow
   task automatic test_updown();
      wb(1'b1, `UDRT_CTRL_OFS, 32'h06);
      wb(1'b1, `UDRT_CNTL_OFS, 32'h10);
      wb(1'b1, `UDRT_CNTH_OFS, 32'h00);
      pulse();
      rd(`UDRT_CNTL_OFS, 32'h11);
      wb(1'b1, `UDRT_MODE_OFS, 32'h01);
      wb(1'b1, `UDRT_RLDL_OFS, 32'h05);
      wb(1'b1, `UDRT_RLDH_OFS, 32'h00);
      wb(1'b1, `UDRT_CNTL_OFS, 32'h05);
      pulse();
      rd(`UDRT_CNTL_OFS, 32'hFF);
      rd(`UDRT_CNTH_OFS, 32'hFF);
      rd(`UDRT_CTRL_OFS, 32'hC6);
      rd(`UDRT_ISTAT_OFS, 32'h01);
      dir <= 1'b1;
      pulse();
      rd(`UDRT_CNTL_OFS, 32'h05);
      rd(`UDRT_CTRL_OFS, 32'h86);
      $display("test_updown done");
   endtask : test_updown
   task automatic test_modes();
      wb(1'b1, `UDRT_ISTAT_OFS, 32'h03);
      chk_irq(1'b0);
      // Baud selects: wrap reloads but leaves the flag alone
      wb(1'b1, `UDRT_CTRL_OFS, 32'h16);
      wb(1'b1, `UDRT_CNTL_OFS, 32'hFF);
      wb(1'b1, `UDRT_CNTH_OFS, 32'hFF);
      pulse();
      rd(`UDRT_CNTL_OFS, 32'h05);
      rd(`UDRT_CTRL_OFS, 32'h16);
      rd(`UDRT_ISTAT_OFS, 32'h00);
      // Plain reload mode: direction pin fall reloads and flags
      wb(1'b1, `UDRT_MODE_OFS, 32'h00);
      wb(1'b1, `UDRT_CTRL_OFS, 32'h0E);
      wb(1'b1, `UDRT_CNTL_OFS, 32'h20);
      dir <= 1'b0;
      repeat (6) @(posedge clk_i);
      rd(`UDRT_CNTL_OFS, 32'h05);
      rd(`UDRT_CTRL_OFS, 32'h4E);
      rd(`UDRT_ISTAT_OFS, 32'h02);
      // Capture stand-in wraps to zero and sets the flag
      wb(1'b1, `UDRT_CTRL_OFS, 32'h07);
      wb(1'b1, `UDRT_CNTL_OFS, 32'hFF);
      wb(1'b1, `UDRT_CNTH_OFS, 32'hFF);
      pulse();
      rd(`UDRT_CNTL_OFS, 32'h00);
      rd(`UDRT_CTRL_OFS, 32'h87);
      $display("test_modes done");
   endtask : test_modes
   task automatic end_of_test();
      $display("Counts: errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      end_of_test();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      test_reset();
      test_carry();
      test_overflow();
      test_updown();
      test_modes();
      end_of_test();
   end
endmodule : tb

// file: verification/udrt_pin_model.sv
// External count and direction pin source
`timescale 1ns/1ps
module udrt_pin_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Requests
   input wire logic go_i,
   input wire logic dir_i,
   // Pins
   output logic count_pin_o,
   output logic dir_pin_o
);
   // ==========================================
   // Low phase of 3 clk, above the 2 clk minimum
   logic [1:0] low_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) low_r <= 2'h0;
      else if (go_i) low_r <= 2'h3;
      else if (low_r != 2'h0) low_r <= low_r - 2'h1;
   end
   assign count_pin_o = (low_r == 2'h0);
   assign dir_pin_o = dir_i;
endmodule : udrt_pin_model

// file: verification/udrt_timer_asserts.sv
// Bus and interrupt checks for the reload timer
`timescale 1ns/1ps
module udrt_timer_asserts (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins and interrupt
   input wire logic count_input_pin_i,
   input wire logic direction_pin_i,
   input wire logic irq_o
);
   // ==========================================
   // Properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   chk_ack_follows: assert property (take |=> wb_ack_o) else $error("ack missing");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   chk_ack_cause: assert property (wb_ack_o |-> $past(take)) else $error("ack unasked");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
   chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("dat top");
   chk_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i >= 8'h20 |=>
      wb_dat_o == 32'h0) else $error("unmapped read");
   chk_irq_sw_clear: assert property ($fell(irq_o) |-> $past(take && wb_we_i, 2))
      else $error("irq dropped alone");
   chk_idle_quiet: assert property ((!wb_cyc_i) [*2] |-> !wb_ack_o) else $error("idle ack");
endmodule : udrt_timer_asserts

bind udrt_timer udrt_timer_asserts u_udrt_timer_asserts (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .count_input_pin_i(count_input_pin_i), .direction_pin_i(direction_pin_i), .irq_o(irq_o));
